// File: pkg/mis_cfg.svh
`ifndef MIS_CFG_SVH
`define MIS_CFG_SVH
// register addresses on the serial port
`define MIS_ADDR_MODE        5'h06
`define MIS_ADDR_FLAGS       5'h04
`define MIS_ADDR_FLAGS_CLR   5'h05
`define MIS_ADDR_ENABLE      5'h0a
// status bit positions
`define MIS_BIT_HALF_FULL    3'd0
`define MIS_BIT_DIP          3'd1
`define MIS_BIT_WAVE         3'd3
`define MIS_BIT_ZERO_CROSS   3'd4
`define MIS_BIT_TEMP         3'd5
`define MIS_BIT_OVERFLOW     3'd7
// latched flags, zero cross is live
`define MIS_LATCH_MASK       8'haf
// mode field positions
`define MIS_MODE_CAL         7
`define MIS_MODE_RATE_LO     11
`define MIS_MODE_SRC_LO      13
`define MIS_MODE_TEST        15
// reset values
`define MIS_RST_MODE         16'h000c
`define MIS_RST_ENABLE       8'h00
// waveform update divider periods in master clock cycles
`define MIS_DIV_128          11'd128
`define MIS_DIV_256          11'd256
`define MIS_DIV_512          11'd512
`define MIS_DIV_1024         11'd1024
`endif

// File: pkg/mis_pkg.sv
package mis_pkg;
   typedef enum logic [1:0] {
      MIS_SRC_POWER    = 2'b00,
      MIS_SRC_RESERVED = 2'b01,
      MIS_SRC_CH1      = 2'b10,
      MIS_SRC_CH2      = 2'b11
   } mis_src_type;

   typedef struct packed {
      logic half_full;
      logic overflow;
      logic dip;
      logic cal_done;
      logic temp_ready;
      logic zero_cross;
   } mis_event_type;

   typedef struct packed {
      logic [4:0]  addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } mis_req_type;
endpackage

// File: core/mis_irq_ctrl.sv
`include "mis_cfg.svh"

// Overview of operation
// - each monitored event sets its status flag to one
// - request pin low while any set flag has its enable bit set
// - bit 0 set on energy msb rising from zero to one
// - bit 1 set on voltage dip or loss of zero crossings
// - in calibration mode bit 1 also marks integration end
// - bit 3 set each time a new waveform sample is loaded
// - bit 4 follows the live zero-crossing output
// - bit 5 set when a temperature result is stored
// - bit 7 set when the energy register overflows
// - rate codes 00 and 01 give divide by 128 and 256
// - mode bits 14:13 choose power, reserved, channel 1, channel 2
// - mode bit 15 enters factory test; keep zero in use
module mis_irq_ctrl
(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   reset_n,
   // register access from the serial port
   input  wire mis_pkg::mis_req_type   req,
   output logic [15:0]                 rdata,
   // events from the metering units
   input  wire mis_pkg::mis_event_type evt,
   // waveform samples by source
   input  wire logic [19:0]            smp_power,
   input  wire logic [19:0]            smp_ch1,
   input  wire logic [19:0]            smp_ch2,
   // outputs
   output logic [19:0]                 wave_data,
   output logic                        wave_load,
   output mis_pkg::mis_src_type        waveform_source_select,
   output logic                        calibration_mode_bit,
   output logic                        factory_test_bit,
   output logic                        irq_n
);

   logic [15:0] mode_ff,    nxt_mode;
   logic [7:0]  enable_ff,  nxt_enable;
   logic [7:0]  flags_ff,   nxt_flags;
   logic [10:0] div_ff,     nxt_div;
   logic [19:0] wave_ff,    nxt_wave;
   logic        msb_ff,     nxt_msb;
   logic        irq_ff,     nxt_irq;
   logic [15:0] rdata_ff,   nxt_rdata;
   logic        tick;
   logic [7:0]  set_vec;
   logic [7:0]  status;

   function automatic logic [10:0] rate_period(input logic [1:0] code);
      case (code)
         2'b00:   rate_period = `MIS_DIV_128;
         2'b01:   rate_period = `MIS_DIV_256;
         2'b10:   rate_period = `MIS_DIV_512;
         default: rate_period = `MIS_DIV_1024;
      endcase
   endfunction

   // waveform rate divider, one-cycle enable on wrap
   always_comb
   begin
      tick = (div_ff >= rate_period(mode_ff[`MIS_MODE_RATE_LO +: 2]) - 11'd1);
      nxt_div = tick ? 11'd0 : div_ff + 11'd1;
   end

   // source select; reserved code loads zero
   always_comb
   begin
      nxt_wave = wave_ff;
      if (tick)
      begin
         case (mode_ff[`MIS_MODE_SRC_LO +: 2])
            2'b00:   nxt_wave = smp_power;
            2'b10:   nxt_wave = smp_ch1;
            2'b11:   nxt_wave = smp_ch2;
            default: nxt_wave = 20'h0_0000;
         endcase
      end
   end

   // event to flag set vector
   always_comb
   begin
      nxt_msb = evt.half_full;
      set_vec = 8'h00;
      set_vec[`MIS_BIT_HALF_FULL] = evt.half_full & ~msb_ff;
      set_vec[`MIS_BIT_DIP] = evt.dip
         | (evt.cal_done & mode_ff[`MIS_MODE_CAL]);
      set_vec[`MIS_BIT_WAVE] = tick;
      set_vec[`MIS_BIT_TEMP] = evt.temp_ready;
      set_vec[`MIS_BIT_OVERFLOW] = evt.overflow;
   end

   // status view: latched flags plus live zero-cross
   always_comb
   begin
      status = flags_ff & `MIS_LATCH_MASK;
      status[`MIS_BIT_ZERO_CROSS] = evt.zero_cross;
   end

   // register writes, clear-on-read, set wins over clear
   always_comb
   begin
      nxt_mode = mode_ff;
      nxt_enable = enable_ff;
      nxt_flags = flags_ff;
      nxt_rdata = rdata_ff;
      if (req.wr)
      begin
         if (req.addr == `MIS_ADDR_MODE)
            nxt_mode = req.wdata;
         else if (req.addr == `MIS_ADDR_ENABLE)
            nxt_enable = req.wdata[7:0];
      end
      if (req.rd)
      begin
         if (req.addr == `MIS_ADDR_MODE)
            nxt_rdata = mode_ff;
         else if (req.addr == `MIS_ADDR_ENABLE)
            nxt_rdata = {8'h00, enable_ff};
         else if (req.addr == `MIS_ADDR_FLAGS)
            nxt_rdata = {8'h00, status};
         else if (req.addr == `MIS_ADDR_FLAGS_CLR)
         begin
            nxt_rdata = {8'h00, status};
            nxt_flags = 8'h00;
         end
         else
            nxt_rdata = 16'h0000;
      end
      nxt_flags = (nxt_flags | set_vec) & `MIS_LATCH_MASK;
      nxt_irq = ~|(status & enable_ff);
   end

   // divider state
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         div_ff <= 11'd0;
      end
      else
      begin
         div_ff <= nxt_div;
      end
   end

   // waveform sample register
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wave_ff <= 20'h0_0000;
      end
      else
      begin
         wave_ff <= nxt_wave;
      end
   end

   // msb edge detector; resets low like an empty energy register
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         msb_ff <= 1'b0;
      end
      else
      begin
         msb_ff <= nxt_msb;
      end
   end

   // registers, flags, read data and request line
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_ff   <= `MIS_RST_MODE;
         enable_ff <= `MIS_RST_ENABLE;
         flags_ff  <= 8'h00;
         irq_ff    <= 1'b1;
         rdata_ff  <= 16'h0000;
      end
      else
      begin
         mode_ff   <= nxt_mode;
         enable_ff <= nxt_enable;
         flags_ff  <= nxt_flags;
         irq_ff    <= nxt_irq;
         rdata_ff  <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;
   assign wave_data = wave_ff;
   assign wave_load = flags_ff[`MIS_BIT_WAVE];
   assign waveform_source_select = mis_pkg::mis_src_type'(mode_ff[`MIS_MODE_SRC_LO +: 2]);
   assign calibration_mode_bit = mode_ff[`MIS_MODE_CAL];
   assign factory_test_bit = mode_ff[`MIS_MODE_TEST];
   assign irq_n = irq_ff;

   // assertions
   sequence s_clr_read;
      req.rd && req.addr == `MIS_ADDR_FLAGS_CLR && !(|set_vec);
   endsequence

   // a rate change may cut one period short while the divider catches up
   sequence s_steady_tick(logic [1:0] code);
      tick && mode_ff[`MIS_MODE_RATE_LO +: 2] == code
         && $stable(mode_ff[`MIS_MODE_RATE_LO +: 2]);
   endsequence

   sequence s_wave_tick(logic [1:0] src);
      tick && mode_ff[`MIS_MODE_SRC_LO +: 2] == src;
   endsequence

   a_irq_asserts: assert property (@(posedge clk_sys) disable iff (!reset_n)
      |(status & enable_ff) |=> !irq_n)
      else $error("request not driven low for enabled flag");

   a_irq_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(|(status & enable_ff)) |=> irq_n)
      else $error("request held with no enabled flag");

   a_flags_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(req.rd && req.addr == `MIS_ADDR_FLAGS_CLR)
         |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
      else $error("latched flag dropped without clear read");

   a_half_full_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (evt.half_full && !msb_ff) |=> flags_ff[`MIS_BIT_HALF_FULL])
      else $error("half-full flag not set on msb rise");

   a_dip_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      evt.dip |=> flags_ff[`MIS_BIT_DIP])
      else $error("dip flag not set");

   a_cal_dip_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (evt.cal_done && mode_ff[`MIS_MODE_CAL]) |=> flags_ff[`MIS_BIT_DIP])
      else $error("calibration end not flagged");

   a_wave_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      tick |=> flags_ff[`MIS_BIT_WAVE] && wave_load)
      else $error("waveform flag not set on new sample");

   a_wave_power: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_wave_tick(2'b00) |=> wave_data == $past(smp_power))
      else $error("waveform not loaded from power source");

   a_wave_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_wave_tick(2'b01) |=> wave_data == 20'h0_0000)
      else $error("reserved source did not load zero");

   a_wave_ch1: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_wave_tick(2'b10) |=> wave_data == $past(smp_ch1))
      else $error("waveform not loaded from channel 1");

   a_wave_ch2: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_wave_tick(2'b11) |=> wave_data == $past(smp_ch2))
      else $error("waveform not loaded from channel 2");

   a_zero_cross: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (req.rd && req.addr == `MIS_ADDR_FLAGS)
         |=> rdata[`MIS_BIT_ZERO_CROSS] == $past(evt.zero_cross))
      else $error("zero-cross bit not live");

   a_temp_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      evt.temp_ready |=> flags_ff[`MIS_BIT_TEMP])
      else $error("temperature flag not set");

   a_ovf_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
      evt.overflow |=> flags_ff[`MIS_BIT_OVERFLOW])
      else $error("overflow flag not set");

   a_rate_slow: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_steady_tick(2'b11) |-> div_ff == (`MIS_DIV_1024 - 11'd1) ##1 (!tick) [*8])
      else $error("divide by 1024 period wrong");

   a_rate_half: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_steady_tick(2'b10) |-> div_ff == (`MIS_DIV_512 - 11'd1))
      else $error("divide by 512 period wrong");

   a_rate_mid: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_steady_tick(2'b01) |-> div_ff == (`MIS_DIV_256 - 11'd1))
      else $error("divide by 256 period wrong");

   a_rate_fast: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_steady_tick(2'b00) |-> div_ff == (`MIS_DIV_128 - 11'd1))
      else $error("divide by 128 period wrong");

   a_mode_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (req.wr && req.addr == `MIS_ADDR_MODE) |=> mode_ff == $past(req.wdata))
      else $error("mode write did not land");

   a_clear_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_clr_read |=> flags_ff == 8'h00 && rdata[7:0] == $past(status))
      else $error("clear-on-read failed");
endmodule

// File: dv/mis_mcu_model.sv
module mis_mcu_model
(
   // clock and request line
   input  wire logic             clk_sys,
   input  wire logic             irq_n,
   // register access
   output mis_pkg::mis_req_type  req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // one access per call, held across exactly one taking edge
   task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
      @(negedge clk_sys);
      req = '{addr: a, wr: w, rd: !w, wdata: d & 16'h7fff};
      @(negedge clk_sys);
      req.wr = 1'b0;
      req.rd = 1'b0;
   endtask
   // status first, then clear-on-read
   task automatic service(output logic seen);
      int n;
      seen = 1'b0;
      for (n = 0; n < 16 && !seen; n++)
      begin
         @(negedge clk_sys);
         seen = (irq_n === 1'b0);
      end
      if (seen)
      begin
         access(5'h04, 1'b0, 16'h0000);
         access(5'h05, 1'b0, 16'h0000);
      end
   endtask
endmodule

// File: dv/mis_irq_ctrl_bench.sv
`include "mis_cfg.svh"
module mis_irq_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clk_sys = 1'b0;
   logic                   reset_n = 1'b0;
   mis_pkg::mis_req_type   req;
   mis_pkg::mis_event_type evt = '0;
   mis_pkg::mis_src_type   src;
   logic [19:0]            smp_power = 20'h0, smp_ch1 = 20'h0, smp_ch2 = 20'h0;
   logic [19:0]            wave_data, v1;
   logic [15:0]            rdata, q_exp[$], q_msk[$];
   logic                   wave_load, cal_bit, test_bit, irq_n, seen, rd_seen = 1'b0;
   logic [5:0]             ev_tbl[4] = '{6'h10, 6'h08, 6'h04, 6'h02};
   logic [15:0]            bit_tbl[4] = '{16'h0080, 16'h0002, 16'h0002, 16'h0020};
   int                     fail_count = 0, num_checks = 0, cycles = 0, i;
   always #4 clk_sys = ~clk_sys;
   mis_irq_ctrl mis_irq_ctrl_inst (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
      .rdata(rdata), .evt(evt), .smp_power(smp_power), .smp_ch1(smp_ch1),
      .smp_ch2(smp_ch2), .wave_data(wave_data), .wave_load(wave_load),
      .waveform_source_select(src), .calibration_mode_bit(cal_bit),
      .factory_test_bit(test_bit), .irq_n(irq_n));
   mis_mcu_model mis_mcu_model_inst (.clk_sys(clk_sys), .irq_n(irq_n), .req(req));
   task automatic close_out();
      chk(q_exp.size(), 0);
      if (fail_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic note(input logic [15:0] e, input logic [15:0] m);
      q_exp.push_back(e);
      q_msk.push_back(m);
   endtask
   // flag reads ignore bit 3, except the last one, which checks bit 3 alone: the waveform tick sets it on its own
   task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
      note(e, m);
      mis_mcu_model_inst.access(a, 1'b0, 16'h0000);
   endtask
   task automatic pulse(input logic [5:0] m);
      @(negedge clk_sys);
      evt = evt | m;
      @(negedge clk_sys);
      evt = evt & ~m;
   endtask
   task automatic wait_change();
      int n;
      v1 = wave_data;
      for (n = 0; n < 1100 && wave_data === v1; n++)
         @(negedge clk_sys);
   endtask
   always @(negedge clk_sys) smp_ch1 <= smp_ch1 + 20'h1;
   always @(posedge clk_sys) rd_seen <= req.rd;
   always @(negedge clk_sys)
      if (rd_seen)
      begin
         if (q_exp.size() == 0)
            chk(32'h0000dead, 32'h0);
         else
            chk(rdata & q_msk.pop_front(), q_exp.pop_front());
      end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         close_out();
      end
   end
   initial
   begin
      void'($urandom(32'h8bb10c00));
      smp_power = 20'($urandom);
      smp_ch2 = 20'($urandom);
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys) reset_n = 1'b1;
      chk(irq_n, 1);
      rd(`MIS_ADDR_MODE, `MIS_RST_MODE, 16'hffff);
      rd(`MIS_ADDR_ENABLE, 16'h0000, 16'hffff);
      rd(`MIS_ADDR_FLAGS, 16'h0000, 16'hfff7);
      mis_mcu_model_inst.access(`MIS_ADDR_MODE, 1'b1, 16'h0080);
      chk(cal_bit, 1);
      for (i = 0; i < 4; i++)
      begin
         pulse(ev_tbl[i]);
         rd(`MIS_ADDR_FLAGS_CLR, bit_tbl[i], 16'hfff7);
         rd(`MIS_ADDR_FLAGS, 16'h0000, 16'hfff7);
      end
      evt.half_full = 1'b1;
      rd(`MIS_ADDR_FLAGS_CLR, 16'h0001, 16'hfff7);
      rd(`MIS_ADDR_FLAGS_CLR, 16'h0000, 16'hfff7);
      evt = '0;
      evt.zero_cross = 1'b1;
      rd(`MIS_ADDR_FLAGS, 16'h0010, 16'hfff7);
      evt.zero_cross = 1'b0;
      rd(`MIS_ADDR_FLAGS, 16'h0000, 16'hfff7);
      mis_mcu_model_inst.access(`MIS_ADDR_ENABLE, 1'b1, 16'h0020);
      pulse(6'h10);
      repeat (4) @(negedge clk_sys);
      chk(irq_n, 1);
      rd(`MIS_ADDR_FLAGS_CLR, 16'h0080, 16'hfff7);
      pulse(6'h02);
      note(16'h0020, 16'hfff7);
      note(16'h0020, 16'hfff7);
      mis_mcu_model_inst.service(seen);
      chk(seen, 1);
      repeat (3) @(negedge clk_sys);
      chk(irq_n, 1);
      mis_mcu_model_inst.access(`MIS_ADDR_ENABLE, 1'b1, 16'h0010);
      evt.zero_cross = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(irq_n, 0);
      evt.zero_cross = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(irq_n, 1);
      for (i = 0; i < 4; i++)
      begin
         mis_mcu_model_inst.access(`MIS_ADDR_MODE, 1'b1, 16'h4000 | 16'(i << 11));
         wait_change();
         wait_change();
         chk(32'(wave_data - v1), 32'(128 << i));
      end
      chk(wave_load, 1);
      rd(`MIS_ADDR_FLAGS, 16'h0008, 16'h0008);
      for (i = 0; i < 4; i++)
      begin
         mis_mcu_model_inst.access(`MIS_ADDR_MODE, 1'b1, 16'(i << 13));
         repeat (300) @(negedge clk_sys);
         chk(src, i);
         if (i != 2)
            chk(wave_data, (i == 0) ? smp_power : (i == 1) ? 20'h0 : smp_ch2);
      end
      chk(test_bit, 0);
      close_out();
   end
endmodule
